// ### hdl/rapc_power_ctrl.v
// Routing, auxiliary converter threshold monitor and power control.
// Assumes a host on the serial control pins and an analogue converter
// that answers each start pulse with a level and a one-cycle valid on mclk.
`timescale 1ns/1ps
`include "rapc_map.vh"

// Notes on behaviour
// R01 - Routing bits 13:12 steer modulator outputs
// R02 - Host writes zeros to reserved routing bits
// R03 - Bits 5:4 select analogue input
// R04 - Bits 3:2 select audio output; 11 reserved
// R05 - Bit1 ramps up, bit0 ramps down
// R06 - High threshold 15:8, low threshold 7:0
// R07 - Level above high/below low sets flag
// R08 - Flag interrupts only when its mask set
// R09 - Status read clears high and low flags
// R10 - Host keeps high threshold at least low
// R11 - No threshold/timing rewrite while converter on
// R12 - Timing bits 5:0 set conversion interval
// R13 - Auto start interval at most 125 us
// R14 - Timing bits 7:6 select converter source
// R15 - Power bits 15:5 enable blocks when set
// R16 - Bus or power reset clears power word
// R17 - Bit5 low holds signal processing reset
// R18 - Bit5 rise with bit4 low restores defaults
// R19 - Bit3 stops crystal, bit2 stops clock out
// R20 - Bit1 enables converter and its interrupts
// R21 - Bit0 starts receive above high threshold
// R22 - Host keeps bit0 low during programming
// R23 - Interrupt line low while irq and mask
// R24 - Defaults restored on unretained reset release
// R25 - One comparison per finished conversion
module rapc_power_ctrl
#(
    parameter TICK_CYCLES = `RAPC_AUX_TICK_NS / `RAPC_MCLK_PERIOD_NS
)
(
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Host serial link
    input wire serClk,
    input wire serSel_b,
    input wire serDataIn,
    output wire replyData,
    output wire replyOe,
    output reg host_irq_line_b,
    // Signal routing
    output reg [1:0] modRouting,
    output reg [1:0] inputSelect,
    output reg [1:0] audioSelect,
    output reg rampUpPulse,
    output reg rampDownPulse,
    // Auxiliary converter
    output reg [1:0] auxSourceSelect,
    output reg auxEnable,
    output reg convStart,
    input wire adcValid,
    input wire [7:0] adcLevel,
    output reg rxAutoStart,
    // Power control
    output reg [10:0] blockPowerEn,
    output reg dspReset,
    output reg progDefaultLoad,
    output reg xtalPowerDown,
    output reg clockOutEnable
);

// ==========================================================
// Serial port
wire cmdStrobe;
wire [7:0] cmdAddr;
wire wrStrobe;
wire [15:0] wrData;
reg [15:0] statusWord;

rapc_serial_port uPort
(
    .mclk(mclk),
    .rst_b(rst_b),
    .serClk(serClk),
    .serSel_b(serSel_b),
    .serDataIn(serDataIn),
    .replyData(replyData),
    .replyOe(replyOe),
    .rdData(statusWord),
    .cmdStrobe(cmdStrobe),
    .cmdAddr(cmdAddr),
    .wrStrobe(wrStrobe),
    .wrData(wrData)
);

// ==========================================================
// Registers
reg [15:0] routing_reg;
reg [15:0] thresh_reg;
reg [7:0] timing_reg;
reg [15:0] power_reg;
reg [15:0] mask_reg;
reg sigHigh_reg;
reg sigLow_reg;
reg irq_reg;
wire busReset;
wire statusRead;
wire [15:0] power_next;

// Strobe qualified by one command address; shared by the reset, status, routing and power decodes
function addrHit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
        addrHit = strobe && (addr == target);
    end
endfunction

// Command decodes and the value a power write will load
assign busReset = addrHit(cmdStrobe, cmdAddr, `RAPC_ADDR_BUS_RESET);
assign statusRead = addrHit(cmdStrobe, cmdAddr, `RAPC_ADDR_STATUS);
assign power_next = wrData;

// Status word as read back by the host; unused bits read as zero
always @*
begin
    statusWord = 16'h0000;
    statusWord[`RAPC_ST_IRQ] = irq_reg;
    statusWord[`RAPC_ST_SIG_HIGH] = sigHigh_reg;
    statusWord[`RAPC_ST_SIG_LOW] = sigLow_reg;
end

// Write decode; bus reset restores the reset values
always @(posedge mclk)
begin
    if (!rst_b || busReset)
    begin
        routing_reg <= `RAPC_ROUTING_RST;
        thresh_reg <= `RAPC_THRESH_RST;
        timing_reg <= `RAPC_TIMING_RST;
        power_reg <= `RAPC_POWER_RST; // [R16]
        mask_reg <= `RAPC_MASK_RST;
    end
    else if (wrStrobe)
    begin
        case (cmdAddr)
            `RAPC_ADDR_ROUTING: routing_reg <= wrData;
            `RAPC_ADDR_THRESH: thresh_reg <= wrData; // [R06]
            `RAPC_ADDR_TIMING: timing_reg <= wrData[7:0];
            `RAPC_ADDR_POWER: power_reg <= power_next;
            `RAPC_ADDR_MASK: mask_reg <= wrData;
            default: routing_reg <= routing_reg;
        endcase
    end
end

// ==========================================================
// Conversion interval timer
reg [12:0] tickCnt_reg;
reg [5:0] intervalCnt_reg;
wire tickDone;
wire [5:0] intervalLast;

// End of one converter tick
assign tickDone = (tickCnt_reg == TICK_CYCLES[12:0] - 13'h0001);
// Zero interval still converts once per tick
assign intervalLast = (timing_reg[`RAPC_TM_INT_HI:`RAPC_TM_INT_LO] == 6'h00) ?
    6'h00 : timing_reg[`RAPC_TM_INT_HI:`RAPC_TM_INT_LO] - 6'h01;

// Start a conversion every interval while enabled
always @(posedge mclk)
begin
    if (!rst_b || !power_reg[`RAPC_PD_AUX_EN])
    begin
        tickCnt_reg <= 13'h0000;
        intervalCnt_reg <= 6'h00;
        convStart <= 1'b0;
    end
    else
    begin
        convStart <= 1'b0;
        if (tickDone)
        begin
            tickCnt_reg <= 13'h0000;
            if (intervalCnt_reg >= intervalLast)
            begin
                intervalCnt_reg <= 6'h00;
                convStart <= 1'b1; // [R12]
            end
            else
            begin
                intervalCnt_reg <= intervalCnt_reg + 6'h01;
            end
        end
        else
        begin
            tickCnt_reg <= tickCnt_reg + 13'h0001;
        end
    end
end

// ==========================================================
// Threshold monitor and interrupt
wire aboveHigh;
wire belowLow;
wire setHigh;
wire setLow;
wire irqEvent;

// Compare each finished conversion against both thresholds
assign aboveHigh = adcLevel > thresh_reg[`RAPC_TH_HIGH_HI:`RAPC_TH_HIGH_LO];
assign belowLow = adcLevel < thresh_reg[`RAPC_TH_LOW_HI:`RAPC_TH_LOW_LO];
assign setHigh = adcValid && power_reg[`RAPC_PD_AUX_EN] && aboveHigh; // [R07] [R20] [R25]
assign setLow = adcValid && power_reg[`RAPC_PD_AUX_EN] && belowLow; // [R07] [R25]
assign irqEvent = (setHigh && !sigHigh_reg && mask_reg[`RAPC_ST_SIG_HIGH]) ||
    (setLow && !sigLow_reg && mask_reg[`RAPC_ST_SIG_LOW]); // [R08]

// Sticky flags; a new event wins over the read clear
always @(posedge mclk)
begin
    if (!rst_b || busReset)
    begin
        sigHigh_reg <= 1'b0;
        sigLow_reg <= 1'b0;
        irq_reg <= 1'b0;
    end
    else
    begin
        sigHigh_reg <= setHigh | (sigHigh_reg & ~statusRead); // [R09]
        sigLow_reg <= setLow | (sigLow_reg & ~statusRead); // [R09]
        irq_reg <= irqEvent | (irq_reg & ~statusRead);
    end
end

// Interrupt line and auto receive start
always @(posedge mclk)
begin
    if (!rst_b)
    begin
        host_irq_line_b <= 1'b1;
        rxAutoStart <= 1'b0;
    end
    else
    begin
        host_irq_line_b <= ~(irq_reg & mask_reg[`RAPC_ST_IRQ]); // [R23]
        rxAutoStart <= setHigh && power_reg[`RAPC_PD_AUTO_RX]; // [R21]
    end
end

// ==========================================================
// Routing, ramp and power outputs
wire routingWrite;
wire powerWrite;
wire dspRise;

// Write decodes for the ramp requests and the power word
assign routingWrite = addrHit(wrStrobe, cmdAddr, `RAPC_ADDR_ROUTING);
assign powerWrite = addrHit(wrStrobe, cmdAddr, `RAPC_ADDR_POWER);
assign dspRise = powerWrite && !power_reg[`RAPC_PD_DSP] && power_next[`RAPC_PD_DSP];

// Drive the analogue controls from the registers
always @(posedge mclk)
begin
    if (!rst_b)
    begin
        modRouting <= 2'h0;
        inputSelect <= 2'h0;
        audioSelect <= 2'h0;
        rampUpPulse <= 1'b0;
        rampDownPulse <= 1'b0;
        auxSourceSelect <= 2'h0;
        auxEnable <= 1'b0;
        blockPowerEn <= 11'h000;
        dspReset <= 1'b1;
        progDefaultLoad <= 1'b0;
        xtalPowerDown <= 1'b0;
        clockOutEnable <= 1'b1;
    end
    else
    begin
        modRouting <= routing_reg[`RAPC_RT_MOD_HI:`RAPC_RT_MOD_LO]; // [R01]
        inputSelect <= routing_reg[`RAPC_RT_IN_HI:`RAPC_RT_IN_LO]; // [R03]
        // Reserved audio code falls back to bias level
        if (routing_reg[`RAPC_RT_AUD_HI:`RAPC_RT_AUD_LO] == `RAPC_AUDIO_RESERVED)
        begin
            audioSelect <= 2'h0; // [R04]
        end
        else
        begin
            audioSelect <= routing_reg[`RAPC_RT_AUD_HI:`RAPC_RT_AUD_LO]; // [R04]
        end
        // One pulse per routing write with the ramp bit set
        rampUpPulse <= routingWrite &&
            wrData[`RAPC_RT_RAMP_UP]; // [R05]
        rampDownPulse <= routingWrite &&
            wrData[`RAPC_RT_RAMP_DN]; // [R05]
        auxSourceSelect <= timing_reg[`RAPC_TM_SRC_HI:`RAPC_TM_SRC_LO]; // [R14]
        auxEnable <= power_reg[`RAPC_PD_AUX_EN]; // [R20]
        blockPowerEn <= power_reg[`RAPC_PD_BLOCK_HI:`RAPC_PD_BLOCK_LO]; // [R15]
        dspReset <= ~power_reg[`RAPC_PD_DSP]; // [R17]
        progDefaultLoad <= dspRise && !power_next[`RAPC_PD_KEEP_PROG]; // [R18] [R24]
        xtalPowerDown <= power_reg[`RAPC_PD_XTAL_OFF]; // [R19]
        clockOutEnable <= ~power_reg[`RAPC_PD_CLKOUT_OFF]; // [R19]
    end
end

endmodule // rapc_power_ctrl

// ### hdl/rapc_map.vh
// Register map, field positions, reset values and timing figures
// for the routing, auxiliary converter and power control block.
// Assumes inclusion by bare name from the design files.
`ifndef RAPC_MAP_VH
`define RAPC_MAP_VH

// ==========================================================
// Command addresses on the serial control bus
`define RAPC_ADDR_BUS_RESET 8'h01
`define RAPC_ADDR_ROUTING 8'hB1
`define RAPC_ADDR_THRESH 8'hB2
`define RAPC_ADDR_TIMING 8'hB3
`define RAPC_ADDR_POWER 8'hC0
`define RAPC_ADDR_STATUS 8'hC6
`define RAPC_ADDR_MASK 8'hCE

// ==========================================================
// Serial framing
`define RAPC_ADDR_LAST_BIT 5'h07
`define RAPC_DATA_LAST_BIT 5'h0F

// ==========================================================
// Reset values
`define RAPC_ROUTING_RST 16'h0000
`define RAPC_THRESH_RST 16'hFF00
`define RAPC_TIMING_RST 8'h00
`define RAPC_POWER_RST 16'h0000
`define RAPC_MASK_RST 16'h0000

// ==========================================================
// Field positions: routing word
`define RAPC_RT_MOD_HI 13
`define RAPC_RT_MOD_LO 12
`define RAPC_RT_IN_HI 5
`define RAPC_RT_IN_LO 4
`define RAPC_RT_AUD_HI 3
`define RAPC_RT_AUD_LO 2
`define RAPC_RT_RAMP_UP 1
`define RAPC_RT_RAMP_DN 0
`define RAPC_AUDIO_RESERVED 2'h3

// Field positions: thresholds and timing
`define RAPC_TH_HIGH_HI 15
`define RAPC_TH_HIGH_LO 8
`define RAPC_TH_LOW_HI 7
`define RAPC_TH_LOW_LO 0
`define RAPC_TM_SRC_HI 7
`define RAPC_TM_SRC_LO 6
`define RAPC_TM_INT_HI 5
`define RAPC_TM_INT_LO 0

// Field positions: power word
`define RAPC_PD_BLOCK_HI 15
`define RAPC_PD_BLOCK_LO 5
`define RAPC_PD_DSP 5
`define RAPC_PD_KEEP_PROG 4
`define RAPC_PD_XTAL_OFF 3
`define RAPC_PD_CLKOUT_OFF 2
`define RAPC_PD_AUX_EN 1
`define RAPC_PD_AUTO_RX 0

// Field positions: status and mask
`define RAPC_ST_IRQ 15
`define RAPC_ST_SIG_HIGH 9
`define RAPC_ST_SIG_LOW 8

// ==========================================================
// Timing
`define RAPC_MCLK_PERIOD_NS 4
`define RAPC_AUX_TICK_NS 20800

`endif

// ### hdl/rapc_serial_port.v
// Serial control port: address byte then 16 data bits, MSB first.
// Assumes the host link pins are asynchronous to mclk; all are
// synchronised by two flops before use.
`timescale 1ns/1ps
`include "rapc_map.vh"

module rapc_serial_port
(
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Host link pins
    input wire serClk,
    input wire serSel_b,
    input wire serDataIn,
    output reg replyData,
    output reg replyOe,
    // Register side
    input wire [15:0] rdData,
    output reg cmdStrobe,
    output reg [7:0] cmdAddr,
    output reg wrStrobe,
    output reg [15:0] wrData
);

// ==========================================================
// Synchronisers and edge detection
reg clkS1;
reg clkS2;
reg clkS3;
reg selS1;
reg selS2;
reg datS1;
reg datS2;
wire clkRise;
wire clkFall;

// Two flops per pin, third clock flop only for edges
always @(posedge mclk)
begin
    if (!rst_b)
    begin
        clkS1 <= 1'b0;
        clkS2 <= 1'b0;
        clkS3 <= 1'b0;
        selS1 <= 1'b1;
        selS2 <= 1'b1;
        datS1 <= 1'b0;
        datS2 <= 1'b0;
    end
    else
    begin
        clkS1 <= serClk;
        clkS2 <= clkS1;
        clkS3 <= clkS2;
        selS1 <= serSel_b;
        selS2 <= selS1;
        datS1 <= serDataIn;
        datS2 <= datS1;
    end
end

assign clkRise = clkS2 & ~clkS3;
assign clkFall = ~clkS2 & clkS3;

// ==========================================================
// Frame state
localparam PH_ADDR = 2'h0;
localparam PH_DATA = 2'h1;
localparam PH_DONE = 2'h2;

reg [1:0] phaseReg;
reg [4:0] bitCntReg;
reg [15:0] shiftInReg;
reg [15:0] replyShiftReg;
reg readModeReg;
wire [7:0] addrNow;
wire [15:0] dataNow;

assign addrNow = {shiftInReg[6:0], datS2};
assign dataNow = {shiftInReg[14:0], datS2};

// Shift in on rising link clock; first reply bit loads on the last address rise, the rest change on falling
always @(posedge mclk)
begin
    if (!rst_b)
    begin
        phaseReg <= PH_ADDR;
        bitCntReg <= 5'h00;
        shiftInReg <= 16'h0000;
        replyShiftReg <= 16'h0000;
        readModeReg <= 1'b0;
        replyData <= 1'b0;
        replyOe <= 1'b0;
        cmdStrobe <= 1'b0;
        cmdAddr <= 8'h00;
        wrStrobe <= 1'b0;
        wrData <= 16'h0000;
    end
    else
    begin
        cmdStrobe <= 1'b0;
        wrStrobe <= 1'b0;
        if (selS2)
        begin
            // Deselect aborts any partial frame
            phaseReg <= PH_ADDR;
            bitCntReg <= 5'h00;
            readModeReg <= 1'b0;
            replyOe <= 1'b0;
            replyData <= 1'b0;
        end
        else if (clkRise)
        begin
            shiftInReg <= dataNow;
            case (phaseReg)
                PH_ADDR:
                begin
                    if (bitCntReg == `RAPC_ADDR_LAST_BIT)
                    begin
                        cmdAddr <= addrNow;
                        cmdStrobe <= 1'b1;
                        bitCntReg <= 5'h00;
                        phaseReg <= (addrNow == `RAPC_ADDR_BUS_RESET) ? PH_DONE : PH_DATA;
                        readModeReg <= (addrNow == `RAPC_ADDR_STATUS);
                        if (addrNow == `RAPC_ADDR_STATUS)
                        begin
                            replyOe <= 1'b1;
                            replyData <= rdData[15];
                            replyShiftReg <= {rdData[14:0], 1'b0};
                        end
                    end
                    else
                    begin
                        bitCntReg <= bitCntReg + 5'h01;
                    end
                end
                PH_DATA:
                begin
                    if (bitCntReg == `RAPC_DATA_LAST_BIT)
                    begin
                        phaseReg <= PH_DONE;
                        wrStrobe <= ~readModeReg;
                        wrData <= dataNow;
                    end
                    bitCntReg <= bitCntReg + 5'h01;
                end
                default:
                begin
                    phaseReg <= PH_DONE;
                end
            endcase
        end
        else if (clkFall && readModeReg && phaseReg == PH_DATA && bitCntReg != 5'h00)
        begin
            // Next reply bit after the host sampled the last one
            replyData <= replyShiftReg[15];
            replyShiftReg <= {replyShiftReg[14:0], 1'b0};
        end
        else if (clkFall && readModeReg && phaseReg == PH_DONE)
        begin
            replyOe <= 1'b0;
        end
    end
end

endmodule // rapc_serial_port

// ### verification/rapc_power_ctrl_sva.sv
// Checker for the routing and power control block, bound to its top.
// Assumes the converter and host partners keep the hand-over contract.
`timescale 1ns/1ps

module rapc_power_ctrl_sva
(
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Watched ports
    input wire serSel_b,
    input wire [1:0] modRouting,
    input wire [1:0] audioSelect,
    input wire rampUpPulse,
    input wire rampDownPulse,
    input wire convStart,
    input wire adcValid,
    input wire auxEnable,
    input wire rxAutoStart,
    input wire [10:0] blockPowerEn,
    input wire dspReset,
    input wire progDefaultLoad
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Sequences
    sequence s_convIdle;
        (!convStart)[*7];
    endsequence
    sequence s_loadDone;
        ##[0:2] !dspReset ##1 !progDefaultLoad;
    endsequence

    // ==========================================================
    // Properties
    property p_dspHold;
        dspReset != blockPowerEn[0];
    endproperty
    property p_defaultLoad;
        progDefaultLoad |-> s_loadDone;
    endproperty
    property p_rampPulse;
        (rampUpPulse || rampDownPulse) |=> !(rampUpPulse || rampDownPulse);
    endproperty
    property p_audioCode;
        audioSelect != 2'h3;
    endproperty
    property p_autoStart;
        rxAutoStart |-> $past(adcValid) && auxEnable;
    endproperty
    property p_convGate;
        convStart |-> auxEnable;
    endproperty
    property p_convSpacing;
        convStart |=> s_convIdle;
    endproperty
    property p_writeSettle;
        ($changed(modRouting) || $changed(blockPowerEn)) |-> !$past(serSel_b);
    endproperty

    a_dspHold: assert property (p_dspHold)
        else $error("signal processing reset disagrees with power bit");
    a_defaultLoad: assert property (p_defaultLoad)
        else $error("default load without processing start");
    a_rampPulse: assert property (p_rampPulse)
        else $error("ramp request longer than one cycle");
    a_audioCode: assert property (p_audioCode)
        else $error("reserved audio code reached output");
    a_autoStart: assert property (p_autoStart)
        else $error("receive start without finished conversion");
    a_convGate: assert property (p_convGate)
        else $error("conversion started while converter off");
    a_convSpacing: assert property (p_convSpacing)
        else $error("conversions closer than one interval");
    a_writeSettle: assert property (p_writeSettle)
        else $error("control output changed outside a host frame");
endmodule // rapc_power_ctrl_sva

bind rapc_power_ctrl rapc_power_ctrl_sva uChk
(
    .mclk(mclk),
    .rst_b(rst_b),
    .serSel_b(serSel_b),
    .modRouting(modRouting),
    .audioSelect(audioSelect),
    .rampUpPulse(rampUpPulse),
    .rampDownPulse(rampDownPulse),
    .convStart(convStart),
    .adcValid(adcValid),
    .auxEnable(auxEnable),
    .rxAutoStart(rxAutoStart),
    .blockPowerEn(blockPowerEn),
    .dspReset(dspReset),
    .progDefaultLoad(progDefaultLoad)
);

// ### verification/rapc_host_model.sv
// Host controller model on the serial control link.
// Assumes the link clock stands still low between frames.
`timescale 1ns/1ps

module rapc_host_model
(
    // Host link pins
    output logic serClk,
    output logic serSel_b,
    output logic serDataIn,
    input wire replyData,
    input wire replyOe
);
    // Idle link at time zero
    initial
    begin
        serClk = 1'b0;
        serSel_b = 1'b1;
        serDataIn = 1'b0;
    end

    // ==========================================================
    // One frame: address then nData bits, reply sampled on each data bit rise
    task automatic frame(input logic [7:0] addr, input logic [15:0] word,
        input int nData, output logic [15:0] reply);
        logic [23:0] sh;
        sh = {addr, word};
        reply = 16'h0000;
        serSel_b = 1'b0;
        #24;
        for (int i = 0; i < 8 + nData; i++)
        begin
            serDataIn = sh[23 - i];
            #24;
            serClk = 1'b1;
            if (i >= 8)
                reply = {reply[14:0], replyOe ? replyData : ~replyData}; // Undriven reads wrong
            #24;
            serClk = 1'b0;
        end
        #40;
        serSel_b = 1'b1;
        serDataIn = ~serDataIn; // Released line shows no stale value
        #40;
    endtask
endmodule // rapc_host_model

// ### verification/testbench.sv
// Self-checking bench for the routing and power control block.
// Assumes the host model above and a converter stub in this module.
`timescale 1ns/1ps

module testbench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic adcValid = 1'b0;
    logic [7:0] adcLevel = 8'h00;
    logic pend = 1'b0;
    logic [7:0] upCnt = 8'h00, dnCnt = 8'h00, loadCnt = 8'h00, autoCnt = 8'h00;
    logic [15:0] v;
    logic [15:0] gap = 16'h0000;
    wire serClk, serSel_b, serDataIn, replyData, replyOe, host_irq_line_b;
    wire [1:0] modRouting, inputSelect, audioSelect, auxSourceSelect;
    wire rampUpPulse, rampDownPulse, auxEnable, convStart, rxAutoStart;
    wire [10:0] blockPowerEn;
    wire dspReset, progDefaultLoad, xtalPowerDown, clockOutEnable;
    int fails = 0;
    int checkCount = 0;
    // Routing word beside expected {mod, input, audio}
    logic [21:0] rows [4] = '{22'h000000, 22'h040515, 22'h080A2A, 22'h0C0F3C};

    // ==========================================================
    // Clock, partners and design
    always #2 mclk = ~mclk;

    rapc_host_model host (.serClk(serClk), .serSel_b(serSel_b), .serDataIn(serDataIn),
        .replyData(replyData), .replyOe(replyOe));

    rapc_power_ctrl #(.TICK_CYCLES(8)) DUT (.mclk(mclk), .rst_b(rst_b), .serClk(serClk),
        .serSel_b(serSel_b), .serDataIn(serDataIn), .replyData(replyData),
        .replyOe(replyOe), .host_irq_line_b(host_irq_line_b), .modRouting(modRouting),
        .inputSelect(inputSelect), .audioSelect(audioSelect), .rampUpPulse(rampUpPulse),
        .rampDownPulse(rampDownPulse), .auxSourceSelect(auxSourceSelect),
        .auxEnable(auxEnable), .convStart(convStart), .adcValid(adcValid),
        .adcLevel(adcLevel), .rxAutoStart(rxAutoStart), .blockPowerEn(blockPowerEn),
        .dspReset(dspReset), .progDefaultLoad(progDefaultLoad),
        .xtalPowerDown(xtalPowerDown), .clockOutEnable(clockOutEnable));

    // Converter stub answers each start two cycles later
    always @(negedge mclk)
    begin
        pend <= (convStart === 1'b1);
        adcValid <= pend;
    end

    // Pulse counters
    always @(posedge mclk)
    begin
        upCnt <= upCnt + {7'h00, rampUpPulse === 1'b1};
        dnCnt <= dnCnt + {7'h00, rampDownPulse === 1'b1};
        loadCnt <= loadCnt + {7'h00, progDefaultLoad === 1'b1};
        autoCnt <= autoCnt + {7'h00, rxAutoStart === 1'b1};
    end

    // ==========================================================
    // Tasks
    task chkWord(input string name, input logic [15:0] exp, input logic [15:0] got);
        checkCount++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task chkBit(input string name, input logic exp, input logic got);
        chkWord(name, {15'h0000, exp}, {15'h0000, got});
    endtask

    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] dummy;
        host.frame(a, d, 16, dummy);
        @(negedge mclk);
    endtask

    task rd(output logic [15:0] r);
        host.frame(8'hC6, 16'h0000, 16, r);
        @(negedge mclk);
    endtask

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #300000;
        fails++;
        report_and_stop;
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        chkBit("clockOutEnable", 1'b1, clockOutEnable);
        chkBit("dspReset", 1'b1, dspReset);
        chkBit("replyOe", 1'b0, replyOe);
        $display("Test reset done");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'hB1, rows[i][21:6]);
            chkWord("routing", {10'h000, rows[i][5:0]},
                {10'h000, modRouting, inputSelect, audioSelect});
        end
        $display("Test routing table done");
        wr(8'hB1, 16'h0002);
        wr(8'hB1, 16'h0001);
        chkWord("ramp", 16'h0101, {upCnt, dnCnt});
        wr(8'hCE, 16'h8200);
        wr(8'hB2, 16'hA040);
        wr(8'hB3, 16'h00C2);
        chkWord("auxSourceSelect", 16'h0003, {14'h0000, auxSourceSelect});
        adcLevel = 8'hB0;
        wr(8'hC0, 16'hFFEE);
        chkWord("blockPowerEn", 16'h07FF, {5'h00, blockPowerEn});
        chkBit("dspReset", 1'b0, dspReset);
        chkBit("xtalPowerDown", 1'b1, xtalPowerDown);
        chkBit("clockOutEnable", 1'b0, clockOutEnable);
        chkBit("auxEnable", 1'b1, auxEnable);
        chkWord("loadCnt", 16'h0001, {8'h00, loadCnt});
        // Interval 2 of eight-cycle ticks: 15 idle samples between requests
        for (int i = 0; i < 100 && convStart !== 1'b1; i++)
            @(negedge mclk);
        chkBit("convStart", 1'b1, convStart);
        @(negedge mclk);
        for (int i = 0; i < 100 && convStart !== 1'b1; i++)
        begin
            gap++;
            @(negedge mclk);
        end
        chkWord("interval", 16'h000F, gap);
        for (int i = 0; i < 200 && host_irq_line_b !== 1'b0; i++)
            @(negedge mclk);
        chkBit("host_irq_line_b", 1'b0, host_irq_line_b);
        adcLevel = 8'h80;
        repeat (40) @(negedge mclk);
        rd(v);
        chkWord("status", 16'h8200, v);
        chkBit("host_irq_line_b", 1'b1, host_irq_line_b);
        rd(v);
        chkWord("status", 16'h0000, v);
        adcLevel = 8'h10;
        repeat (40) @(negedge mclk);
        adcLevel = 8'h80;
        repeat (40) @(negedge mclk);
        rd(v);
        chkWord("status", 16'h0100, v);
        chkBit("host_irq_line_b", 1'b1, host_irq_line_b);
        $display("Test monitor done");
        wr(8'hC0, 16'h0000);
        chkBit("dspReset", 1'b1, dspReset);
        wr(8'hC0, 16'hFFF3);
        adcLevel = 8'hB0;
        repeat (40) @(negedge mclk);
        chkBit("rxAutoStart", 1'b1, autoCnt != 8'h00);
        chkWord("loadCnt", 16'h0001, {8'h00, loadCnt});
        chkBit("clockOutEnable", 1'b1, clockOutEnable);
        chkBit("xtalPowerDown", 1'b0, xtalPowerDown);
        wr(8'h77, 16'hFFFF);
        chkWord("unmapped", 16'h0000, {10'h000, modRouting, inputSelect, audioSelect});
        host.frame(8'h01, 16'h0000, 0, v);
        @(negedge mclk);
        chkWord("blockPowerEn", 16'h0000, {5'h00, blockPowerEn});
        chkBit("dspReset", 1'b1, dspReset);
        chkBit("clockOutEnable", 1'b1, clockOutEnable);
        chkBit("xtalPowerDown", 1'b0, xtalPowerDown);
        chkBit("auxEnable", 1'b0, auxEnable);
        $display("Test power and bus reset done");
        report_and_stop;
    end
endmodule // testbench
